/* File: sps_map.svh */
// register offsets, field positions, reset values and timing figures of the sequencer
`ifndef SPS_MAP_SVH
`define SPS_MAP_SVH
`define SPS_ADDR_W        8
`define SPS_OFF_CTRL      8'h00
`define SPS_OFF_POINTER   8'h04
`define SPS_OFF_DATA      8'h08
`define SPS_OFF_STORE     8'h0c
`define SPS_OFF_CONFIG    8'h10
`define SPS_OFF_STATUS    8'h14
`define SPS_BIT_EN        0
`define SPS_BIT_ERASE     1
`define SPS_BIT_WRITE     2
`define SPS_BIT_LOCK      3
`define SPS_BIT_REEN      4
`define SPS_BIT_RBUSY     6
`define SPS_BIT_REFUSED   7
`define SPS_CMD_W         5
`define SPS_LOCK_LSB      8
`define SPS_BOOT_LOCK_BIT 4
`define SPS_BUSY_BIT      16
`define SPS_RESP_OKAY     2'b00
`define SPS_RESP_SLVERR   2'b10
`define SPS_BSZ_RESET     2'b00
`define SPS_LOCK_RESET    6'h3f
`define SPS_ERASED        16'hffff
`define SPS_WINDOW        3'h4
`define SPS_BOOT_END      12'hfff
`define SPS_BOOT_128      12'hf80
`define SPS_BOOT_256      12'hf00
`define SPS_BOOT_512      12'he00
`define SPS_BOOT_1024     12'hc00
`define SPS_NO_READ_WHILE_WRITE_REGION_START    12'hc00
`define SPS_CLK_MHZ       200
`define SPS_RC_MHZ        1
`define SPS_PROG_MIN_US   3700
`define SPS_PROG_MAX_US   4500
`define SPS_RC_DIV        (`SPS_CLK_MHZ / `SPS_RC_MHZ)
`define SPS_PROG_TICKS    (((`SPS_PROG_MIN_US + `SPS_PROG_MAX_US) / 2) * `SPS_RC_MHZ)
`define SPS_MIN_CYC       (`SPS_PROG_MIN_US * `SPS_CLK_MHZ)
`define SPS_MAX_CYC       (`SPS_PROG_MAX_US * `SPS_CLK_MHZ)
`endif

/* File: sps_pkg.sv */
// types and shared decode functions of the self-programming sequencer
`include "sps_map.svh"
package sps_pkg;
    typedef enum logic [1:0] {st_idle, st_armed, st_busy} sps_state_t;

    function automatic logic [11:0] sps_boot_start(input logic [1:0] bsz);
        case (bsz)
            2'b11:   sps_boot_start = `SPS_BOOT_128;
            2'b10:   sps_boot_start = `SPS_BOOT_256;
            2'b01:   sps_boot_start = `SPS_BOOT_512;
            default: sps_boot_start = `SPS_BOOT_1024;
        endcase
    endfunction

    function automatic logic sps_addr_ok(input logic [`SPS_ADDR_W-1:0] a);
        if (a == `SPS_OFF_CTRL || a == `SPS_OFF_POINTER || a == `SPS_OFF_DATA)
            sps_addr_ok = 1'b1;
        else if (a == `SPS_OFF_STORE || a == `SPS_OFF_CONFIG || a == `SPS_OFF_STATUS)
            sps_addr_ok = 1'b1;
        else
            sps_addr_ok = 1'b0;
    endfunction

    function automatic logic [15:0] sps_merge16(input logic [15:0] old_v,
                                                input logic [15:0] new_v,
                                                input logic [1:0]  strb);
        sps_merge16 = {strb[1] ? new_v[15:8] : old_v[15:8], strb[0] ? new_v[7:0] : old_v[7:0]};
    endfunction
endpackage

/* File: sps_timer_if.sv */
// handshake between sequencer control and its program timer
`timescale 1ns/1ps
interface sps_timer_if;
    logic start;
    logic done;
    logic busy;
    modport ctrl  (output start, input done, input busy);
    modport timer (input start, output done, output busy);
endinterface

/* File: sps_prog_timer.sv */
// program/erase timer clocked by the rc oscillator tick
`timescale 1ns/1ps
`include "sps_map.svh"
module sps_prog_timer import sps_pkg::*; #(
    parameter int RC_DIV     = `SPS_RC_DIV,
    parameter int PROG_TICKS = `SPS_PROG_TICKS
) (
    input wire logic   aclk,    // system clock
    input wire logic   aresetn, // sync reset, active low
    sps_timer_if.timer tmr      // start/done handshake
);
    logic [15:0] div_cnt;
    logic [15:0] tick_cnt;
    logic [31:0] elapsed;
    wire         rc_tick = (div_cnt == 16'(RC_DIV - 1));

    // reset is ignored while an operation runs so the flash cell is never cut short;
    // busy is tested first so an unknown power-up busy still falls into reset
    always_ff @(posedge aclk) begin
        if (tmr.busy) begin
            // duration counts rc ticks only, never core cycles
            div_cnt <= rc_tick ? 16'h0000 : div_cnt + 16'h0001;
            if (rc_tick) begin
                tick_cnt <= tick_cnt + 16'h0001;
                if (tick_cnt == 16'(PROG_TICKS - 1)) begin
                    tmr.busy <= 1'b0;
                    tmr.done <= 1'b1;
                end
            end
        end else if (!aresetn) begin
            tmr.busy <= 1'b0;
            tmr.done <= 1'b0;
            div_cnt  <= 16'h0000;
            tick_cnt <= 16'h0000;
        end else if (tmr.start) begin
            tmr.busy <= 1'b1;
            tmr.done <= 1'b0;
            div_cnt  <= 16'h0000;
            tick_cnt <= 16'h0000;
        end else begin
            tmr.done <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (tmr.start && !tmr.busy)
            elapsed <= 32'h0000_0000;
        else if (tmr.busy)
            elapsed <= elapsed + 32'h0000_0001;
    end

    default clocking cb @(posedge aclk); endclocking

    chk_prog_duration: assert property (tmr.done |-> elapsed == 32'(PROG_TICKS * RC_DIV))
        else $error("program time differs from tick budget");
    chk_timer_survives: assert property ((!aresetn && tmr.busy && !tmr.done) |=> (tmr.busy || tmr.done))
        else $error("timer aborted by reset");
endmodule // sps_prog_timer

/* File: sps_flash_seq.sv */
// Function
// - reset during erase or write lets the operation finish
// - operation time comes from rc oscillator ticks, not core cycles
// - each erase, write or lock write lasts 3.7 to 4.5 ms
// - boot size code picks 128/256/512/1024 words ending at 0xfff
// - boot vector is the first word of the boot section
// - words 0x000-0xbff unreadable during erase or write
// - words 0xc00-0xfff stay readable during programming
// - twelve-bit word address, 4096 flash words
// - 32-word pages, buffer indexed by low five address bits
// - page number taken from pointer bits 12 to 6
// - buffer word taken from pointer bits 5 to 1
// - pointer bits 15 to 13 ignored
// - pointer bit 0 zero for stores, byte select for loads
// - busy flag set means read region not ready
// - only upper region readable during erase or write
// - boot lock refuses writes into boot section
// - command valid only if store follows within four cycles
// - page buffer erased after write, re-enable and reset
`timescale 1ns/1ps
`include "sps_map.svh"
module sps_flash_seq import sps_pkg::*; #(
    parameter int RC_DIV     = `SPS_RC_DIV,
    parameter int PROG_TICKS = `SPS_PROG_TICKS
) (
    input  wire logic                   aclk,       // 200 MHz clock
    input  wire logic                   aresetn,    // sync reset, active low
    input  wire logic [`SPS_ADDR_W-1:0] awaddr,     // write address
    input  wire logic                   awvalid,    // write address valid
    output      logic                   awready,    // write address ready
    input  wire logic [31:0]            wdata,      // write data
    input  wire logic [3:0]             wstrb,      // write byte strobes
    input  wire logic                   wvalid,     // write data valid
    output      logic                   wready,     // write data ready
    output      logic [1:0]             bresp,      // write response
    output      logic                   bvalid,     // write response valid
    input  wire logic                   bready,     // write response ready
    input  wire logic [`SPS_ADDR_W-1:0] araddr,     // read address
    input  wire logic                   arvalid,    // read address valid
    output      logic                   arready,    // read address ready
    output      logic [31:0]            rdata,      // read data
    output      logic [1:0]             rresp,      // read response
    output      logic                   rvalid,     // read data valid
    input  wire logic                   rready,     // read data ready
    input  wire logic                   eeprom_write_busy_flag, // eeprom write ongoing
    input  wire logic                   fetch_en,   // core program-memory read
    input  wire logic [15:0]            fetch_z,    // byte pointer of that read
    output      logic [7:0]             fetch_data, // byte read
    output      logic                   fetch_valid,   // read answered, pulse
    output      logic                   fetch_blocked, // read refused, region busy
    output      logic [11:0]            boot_vector,   // boot reset address
    output      logic                   core_halt      // upper-region operation halts core
);
    logic [15:0]            flash [4096];
    logic [15:0]            page_buf [32];
    sps_state_t             state;
    logic [`SPS_CMD_W-1:0]  cmd;
    logic [2:0]             window;
    logic                   read_region_busy_flag;
    logic                   refused;
    logic [15:0]            pointer;
    logic [15:0]            data;
    logic [1:0]             boot_size;
    logic [5:0]             lock_bits;
    logic [6:0]             tgt_page;
    logic                   aw_held;
    logic                   w_held;
    logic [`SPS_ADDR_W-1:0] aw_q;
    logic [31:0]            w_q;
    logic [3:0]             s_q;
    logic [31:0]            next_rdata;

    sps_timer_if tif ();
    sps_prog_timer #(.RC_DIV(RC_DIV), .PROG_TICKS(PROG_TICKS)) u_timer (
        .aclk    (aclk),
        .aresetn (aresetn),
        .tmr     (tif.timer)
    );

    // reset leaves a running operation untouched
    wire soft_rst = !aresetn && (state != st_busy);
    wire do_wr    = aw_held && w_held;
    wire ctrl_wr  = do_wr && (aw_q == `SPS_OFF_CTRL) && s_q[0];
    wire store_wr = do_wr && (aw_q == `SPS_OFF_STORE);
    wire store_hit = store_wr && (state == st_armed);
    wire [6:0] z_page = pointer[12:6];
    wire [4:0] z_word = pointer[5:1];
    wire [11:0] boot_start = sps_boot_start(boot_size);
    wire boot_locked = !lock_bits[`SPS_BOOT_LOCK_BIT];
    wire in_boot = {z_page, 5'h00} >= boot_start;
    wire is_erase = cmd[`SPS_BIT_ERASE];
    wire is_write = cmd[`SPS_BIT_WRITE];
    wire is_lock  = cmd[`SPS_BIT_LOCK];
    wire is_reen  = cmd[`SPS_BIT_REEN];
    wire do_flash = store_hit && (is_erase || is_write);
    wire refuse   = do_flash && boot_locked && in_boot;
    wire go_prog  = (do_flash && !refuse) || (store_hit && is_lock);
    wire do_reen  = store_hit && is_reen && !is_erase && !is_write && !is_lock;
    wire do_load  = store_hit && cmd == `SPS_CMD_W'(1);

    assign tif.start   = go_prog;
    assign boot_vector = boot_start;
    assign awready     = !aw_held && !bvalid;
    assign wready      = !w_held && !bvalid;
    assign arready     = !rvalid;
    assign core_halt   = (state == st_busy) && !is_lock && ({tgt_page, 5'h00} >= `SPS_NO_READ_WHILE_WRITE_REGION_START);

    // bus write side: address and data may come in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            bvalid  <= 1'b0;
            bresp   <= `SPS_RESP_OKAY;
            aw_q    <= '0;
            w_q     <= 32'h0000_0000;
            s_q     <= 4'h0;
        end else begin
            if (awvalid && awready) begin
                aw_held <= 1'b1;
                aw_q    <= awaddr;
            end
            if (wvalid && wready) begin
                w_held <= 1'b1;
                w_q    <= wdata;
                s_q    <= wstrb;
            end
            if (do_wr) begin
                aw_held <= 1'b0;
                w_held  <= 1'b0;
                bvalid  <= 1'b1;
                bresp   <= sps_addr_ok(aw_q) ? `SPS_RESP_OKAY : `SPS_RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        if (araddr == `SPS_OFF_CTRL)
            next_rdata = {24'h000000, refused, read_region_busy_flag, 1'b0, cmd};
        else if (araddr == `SPS_OFF_POINTER)
            next_rdata = {16'h0000, pointer};
        else if (araddr == `SPS_OFF_DATA)
            next_rdata = {16'h0000, data};
        else if (araddr == `SPS_OFF_CONFIG)
            next_rdata = {18'h00000, lock_bits, 6'h00, boot_size};
        else if (araddr == `SPS_OFF_STATUS)
            next_rdata = {15'h0000, tif.busy, 4'h0, boot_start};
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata  <= 32'h0000_0000;
            rresp  <= `SPS_RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata  <= next_rdata;
            rresp  <= sps_addr_ok(araddr) ? `SPS_RESP_OKAY : `SPS_RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end

    // plain registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pointer   <= 16'h0000;
            data      <= 16'h0000;
            boot_size <= `SPS_BSZ_RESET;
        end else if (do_wr) begin
            if (aw_q == `SPS_OFF_POINTER)
                pointer <= sps_merge16(pointer, w_q[15:0], s_q[1:0]);
            else if (aw_q == `SPS_OFF_DATA)
                data <= sps_merge16(data, w_q[15:0], s_q[1:0]);
            else if (aw_q == `SPS_OFF_CONFIG && s_q[0])
                boot_size <= w_q[1:0];
        end
    end

    // command sequencer
    always_ff @(posedge aclk) begin
        if (soft_rst) begin
            state  <= st_idle;
            cmd    <= '0;
            window <= 3'h0;
        end else begin
            case (state)
                st_idle: begin
                    // eeprom write blocks any new command
                    if (ctrl_wr && !eeprom_write_busy_flag) begin
                        cmd <= w_q[`SPS_CMD_W-1:0];
                        if (w_q[`SPS_BIT_EN]) begin
                            state  <= st_armed;
                            window <= `SPS_WINDOW;
                        end
                    end
                end
                st_armed: begin
                    window <= window - 3'h1;
                    if (go_prog) begin
                        state <= st_busy;
                    end else if (store_hit || window == 3'h1) begin
                        state <= st_idle;
                        cmd   <= '0;
                    end
                end
                st_busy: begin
                    if (tif.done) begin
                        state <= st_idle;
                        cmd   <= '0;
                    end
                end
                default: state <= st_idle;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (soft_rst) begin
            read_region_busy_flag <= 1'b0;
            refused               <= 1'b0;
            tgt_page              <= 7'h00;
        end else begin
            if (do_flash && !refuse) begin
                read_region_busy_flag <= 1'b1;
                tgt_page              <= z_page;
            end else if (do_reen && !tif.busy) begin
                read_region_busy_flag <= 1'b0;
            end
            if (refuse)
                refused <= 1'b1;
            else if (ctrl_wr && state == st_idle)
                refused <= 1'b0;
        end
    end

    // lock writes only move bits toward programmed; reset outside busy reloads 0x3f
    always_ff @(posedge aclk) begin
        if (!aresetn && state != st_busy)
            lock_bits <= `SPS_LOCK_RESET;
        else if (store_hit && is_lock)
            lock_bits <= lock_bits & data[5:0];
    end

    // cells take their value at the start; timer only stretches the busy time
    always_ff @(posedge aclk) begin
        for (int i = 0; i < 32; i++) begin
            if (do_flash && !refuse && is_erase)
                flash[{z_page, 5'(i)}] <= `SPS_ERASED;
            else if (do_flash && !refuse && is_write)
                flash[{z_page, 5'(i)}] <= page_buf[i];
        end
    end

    always_ff @(posedge aclk) begin
        for (int i = 0; i < 32; i++) begin
            if (!aresetn || (do_flash && !refuse && is_write) || do_reen)
                page_buf[i] <= `SPS_ERASED;
            else if (do_load && z_word == 5'(i))
                page_buf[i] <= data;
        end
    end

    // core read port; lower region refused while programming or not re-enabled
    wire        f_lower   = fetch_z[12:1] < `SPS_NO_READ_WHILE_WRITE_REGION_START;
    wire        f_blocked = f_lower && (read_region_busy_flag || tif.busy);
    wire [15:0] f_word    = flash[fetch_z[12:1]];
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fetch_valid   <= 1'b0;
            fetch_blocked <= 1'b0;
            fetch_data    <= 8'h00;
        end else begin
            fetch_valid   <= fetch_en;
            fetch_blocked <= fetch_en && f_blocked;
            if (fetch_en && !f_blocked)
                fetch_data <= fetch_z[0] ? f_word[15:8] : f_word[7:0];
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_busy_on_start: assert property ((do_flash && !refuse) |=> read_region_busy_flag)
        else $error("busy flag not set at operation start");
    chk_rww_blocked: assert property ((fetch_en && f_lower && read_region_busy_flag) |=> fetch_blocked)
        else $error("lower region read while busy");
    chk_no_read_while_write_region_open: assert property ((fetch_en && !f_lower) |=> (fetch_valid && !fetch_blocked))
        else $error("upper region read refused");
    chk_window_expire: assert property (
        (ctrl_wr && state == st_idle && w_q[`SPS_BIT_EN] && !eeprom_write_busy_flag)
        ##1 (!store_wr)[*4] |=> (state == st_idle && cmd == '0))
        else $error("command survived past its store window");
    chk_enable_clear: assert property ((state == st_busy && tif.done) |=> !cmd[`SPS_BIT_EN])
        else $error("enable not cleared on completion");
    chk_boot_lock: assert property (refuse |=> (refused && state == st_idle && !tif.busy))
        else $error("locked boot section write not refused");
    chk_boot_vector: assert property ((do_wr && aw_q == `SPS_OFF_CONFIG && s_q[0] && w_q[1:0] == 2'b11)
        |=> boot_vector == `SPS_BOOT_128)
        else $error("boot vector wrong for smallest section");
    chk_buffer_cleared: assert property ((do_flash && !refuse && is_write) |=> page_buf[0] == `SPS_ERASED)
        else $error("page buffer kept data after page write");

    cov_page_erase: cover property ((go_prog && is_erase) ##[1:1000] (state == st_busy));
    cov_page_write: cover property (go_prog && is_write);
    cov_reenable:   cover property (do_reen);
    cov_expire:     cover property (state == st_armed && window == 3'h1 && !store_wr);
endmodule // sps_flash_seq

/* File: sps_core_model.sv */
// core-side program-memory read port model
`timescale 1ns/1ps
module sps_core_model (
    input  wire logic        aclk,          // system clock
    output      logic        fetch_en,      // read request
    output      logic [15:0] fetch_z,       // byte pointer
    input  wire logic [7:0]  fetch_data,    // byte returned
    input  wire logic        fetch_valid,   // read answered
    input  wire logic        fetch_blocked  // read refused
);
    initial begin
        fetch_en = 1'b0;
        fetch_z  = 16'h0000;
    end

    // pointer is scrambled between reads so a stale value cannot pass
    task automatic fetch(input logic [15:0] z, output logic [7:0] d, output logic b);
        fetch_en <= 1'b1;
        fetch_z  <= z;
        @(posedge aclk);
        fetch_en <= 1'b0;
        fetch_z  <= ~z;
        @(negedge aclk);
        d = fetch_data;
        b = fetch_blocked || !fetch_valid;
        @(posedge aclk);
    endtask
endmodule // sps_core_model

/* File: sps_flash_seq_tb.sv */
// self-checking testbench of the self-programming sequencer
`timescale 1ns/1ps
`include "sps_map.svh"
module sps_flash_seq_tb import sps_pkg::*;;
    localparam logic [7:0] CT = `SPS_OFF_CTRL, PT = `SPS_OFF_POINTER, DT = `SPS_OFF_DATA,
        ST = `SPS_OFF_STORE, CF = `SPS_OFF_CONFIG, SA = `SPS_OFF_STATUS;
    logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, arvalid = 0;
    logic        bready = 1, rready = 1, eeprom_write_busy_flag = 0;
    logic [7:0]  awaddr = 0, araddr = 0, fetch_data;
    logic [31:0] wdata = 0, rdata, v;
    logic [3:0]  wstrb = 4'hf;
    logic [1:0]  bresp, rresp, rr, br;
    logic        awready, wready, bvalid, arready, rvalid, fetch_en, fetch_valid;
    logic        fetch_blocked, core_halt, bl;
    logic [15:0] fetch_z, s = 16'd16, z, d;
    logic [11:0] boot_vector;
    logic [7:0]  b8;
    logic [6:0]  pg;
    int          num_errors = 0, num_checks = 0, cyc = 0, t0;

    sps_flash_seq #(.RC_DIV(2), .PROG_TICKS(4)) u_sps_flash_seq (.aclk, .aresetn, .awaddr,
        .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
        .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .eeprom_write_busy_flag, .fetch_en, .fetch_z, .fetch_data, .fetch_valid,
        .fetch_blocked, .boot_vector, .core_halt);
    sps_core_model u_sps_core_model (.aclk, .fetch_en, .fetch_z, .fetch_data, .fetch_valid,
        .fetch_blocked);

    initial begin
        forever #2.5 aclk = ~aclk;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    function automatic logic [11:0] exp_vec(input logic [1:0] c);
        return 12'hfff - (12'h080 << (2'd3 - c)) + 12'h001;
    endfunction

    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // each channel released at its own handshake; bready stays high
    task automatic wr(input logic [7:0] a, input logic [31:0] x);
        logic ha, hw, hb;
        awaddr  <= a;
        wdata   <= x;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        hb = 1'b0;
        while (!hb) begin
            @(negedge aclk);
            ha = awvalid && awready;
            hw = wvalid && wready;
            hb = bvalid;
            br = bresp;
            @(posedge aclk);
            if (ha) awvalid <= 1'b0;
            if (hw) wvalid <= 1'b0;
        end
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] x);
        logic ha, hr;
        araddr  <= a;
        arvalid <= 1'b1;
        hr = 1'b0;
        while (!hr) begin
            @(negedge aclk);
            ha = arvalid && arready;
            hr = rvalid;
            x  = rdata;
            rr = rresp;
            @(posedge aclk);
            if (ha) arvalid <= 1'b0;
        end
    endtask

    task automatic spm(input logic [4:0] c);
        wr(CT, {27'h0, c});
        wr(ST, 32'h0);
        t0 = cyc;
    endtask

    // polls the enable bit; time counts from the store, not from the first poll
    task automatic wait_idle(input int lo, input int hi);
        logic [31:0] x;
        rd(CT, x);
        while (x[0] !== 1'b0) rd(CT, x);
        chk("op length", 32'((cyc - t0) inside {[lo:hi]}), 1);
    endtask

    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            summarize();
        end
    end

    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(CF, v);
        chk("config reset", v & 32'h3f03, 32'h3f00);
        rd(8'h20, v);
        chk("unmapped resp", rr, `SPS_RESP_SLVERR);
        wr(8'h20, 32'h0);
        chk("unmapped wr resp", br, `SPS_RESP_SLVERR);
        for (int i = 0; i < 4; i++) begin
            wr(CF, i);
            chk("config wr resp", br, `SPS_RESP_OKAY);
            rd(SA, v);
            chk("status vector", v[11:0], exp_vec(2'(i)));
            chk("boot vector", boot_vector, exp_vec(2'(i)));
        end
        s = lfsr(s);
        pg = 7'(s[6:0] % 96);
        d = lfsr(s);
        z = {~s[15:13], pg, d[10:6], 1'b0};
        wr(PT, {~s[15:13], pg, 6'h0});
        spm(5'h03);
        chk("core runs", core_halt, 0);
        u_sps_core_model.fetch(z, b8, bl);
        chk("rww blocked", bl, 1);
        u_sps_core_model.fetch(16'h1800 | d[11:0], b8, bl);
        chk("no_read_while_write_region open", bl, 0);
        rd(CT, v);
        chk("busy flag", v[6], 1);
        wait_idle(7, 12);
        wr(PT, z);
        wr(DT, d);
        spm(5'h01);
        wait_idle(1, 4);
        wr(PT, {~s[15:13], pg, 6'h0});
        spm(5'h05);
        wait_idle(7, 12);
        u_sps_core_model.fetch(z, b8, bl);
        chk("still blocked", bl, 1);
        spm(5'h11);
        wait_idle(1, 4);
        rd(CT, v);
        chk("flag cleared", v[6], 0);
        u_sps_core_model.fetch(z, b8, bl);
        chk("low byte", {bl, b8}, {1'b0, d[7:0]});
        u_sps_core_model.fetch(z | 16'h1, b8, bl);
        chk("high byte", b8, d[15:8]);
        wr(CT, 1);
        rd(CT, v);
        chk("armed", v[0], 1);
        repeat (6) @(posedge aclk);
        wr(ST, 0);
        rd(CT, v);
        chk("window lapsed", v[0], 0);
        eeprom_write_busy_flag <= 1'b1;
        wr(CT, 1);
        rd(CT, v);
        chk("eeprom blocks", v[0], 0);
        eeprom_write_busy_flag <= 1'b0;
        wr(PT, 16'h1800);
        spm(5'h03);
        chk("core halted", core_halt, 1);
        wait_idle(7, 12);
        wr(DT, 32'h2f);
        spm(5'h09);
        wait_idle(7, 12);
        rd(CF, v);
        chk("lock bits", v[13:8], 6'h2f);
        wr(PT, 16'h1f00);
        spm(5'h03);
        rd(CT, v);
        chk("refused", v[7:0] & 8'h81, 8'h80);
        wr(PT, {~s[15:13], pg, 6'h0});
        spm(5'h03);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(CT, v);
        chk("op survives reset", v[6:0] & 7'h41, 7'h41);
        wait_idle(7, 12);
        summarize();
    end
endmodule // sps_flash_seq_tb
